/* dv/rtc_rate_trim_props.sv */
// Purpose: Port checks for the rate trim unit
// Assumes: One clock, sync reset
// Notes:   Correction seconds lie beyond short runs
`timescale 1ns/10ps
module rtc_rate_trim_props (
	input wire logic       SYS_CLK_IN,
	input wire logic       RST_IN,
	input wire logic       OSC_IN,
	input wire logic       TRIM_WR_IN,
	input wire logic [7:0] TRIM_WDATA_IN,
	input wire logic [7:0] TRIM_RDATA_OUT,
	input wire logic       SEC_PULSE_OUT,
	input wire logic       CORR_SECOND_OUT,
	input wire logic       RAW_OSC_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);
	// Pipeline must refill after reset before it can be compared
	raw_follow_a: assert property (!$past(RST_IN, 3) && !$past(RST_IN, 2) && !$past(RST_IN)
		|-> RAW_OSC_OUT == $past(OSC_IN, 3)) else $error("raw lag");
	sec_single_a: assert property (SEC_PULSE_OUT |=> !SEC_PULSE_OUT) else $error("wide pulse");
	wr_load_a: assert property (TRIM_WR_IN |=> TRIM_RDATA_OUT == $past(TRIM_WDATA_IN)) else $error("no load");
	rd_hold_a: assert property (!TRIM_WR_IN |=> $stable(TRIM_RDATA_OUT)) else $error("readback moved");
	rst_value_a: assert property ($fell(RST_IN) |-> TRIM_RDATA_OUT == 8'h00) else $error("reset value");
	pulse_rst_a: assert property ($fell(RST_IN) |-> !SEC_PULSE_OUT && !RAW_OSC_OUT) else $error("reset out");
	corr_edge_a: assert property ($changed(CORR_SECOND_OUT) |-> SEC_PULSE_OUT || $past(SEC_PULSE_OUT))
		else $error("corr moved");
	wr_keep_a: assert property (TRIM_WR_IN |=> $stable(CORR_SECOND_OUT) || SEC_PULSE_OUT) else $error("disturb");
	cover property (TRIM_WR_IN);
	cover property (SEC_PULSE_OUT);
	cover property ($rose(RAW_OSC_OUT));
endmodule
bind rtc_rate_trim rtc_rate_trim_props chk (.*);

/* dv/rtc_rate_trim_test.sv */
// Purpose: Bench for the rate trim unit
// Assumes: Crystal toggles once per clock
// Notes:   Only the first second is timed
`timescale 1ns/10ps
module rtc_rate_trim_test;
	logic       SYS_CLK_IN = 1'b0, RST_IN = 1'b1, OSC_IN = 1'b0, TRIM_WR_IN, SEC_PULSE_OUT, CORR_SECOND_OUT, RAW_OSC_OUT;
	logic [7:0] TRIM_WDATA_IN, TRIM_RDATA_OUT;
	int         fails, comparisons, pulses;
	logic [7:0] codes [6] = '{8'h40, 8'h41, 8'h09, 8'h99, 8'h46, 8'hc2};
	rtc_rate_trim uut (.*);
	trim_host_model host (.clk_in(SYS_CLK_IN), .wr_out(TRIM_WR_IN), .wd_out(TRIM_WDATA_IN));
	initial forever #50 SYS_CLK_IN = ~SYS_CLK_IN;
	always @(posedge SYS_CLK_IN) if (SEC_PULSE_OUT === 1'b1) pulses++;
	task automatic check(input string n, input logic [7:0] s, e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge SYS_CLK_IN);
		RST_IN <= 1'b0;
		foreach (codes[i]) begin
			host.put(codes[i]);
			#1 check("readback", TRIM_RDATA_OUT, codes[i]);
		end
		$display("test writes done");
		repeat (65533) @(posedge SYS_CLK_IN) OSC_IN <= ~OSC_IN;
		repeat (8) @(posedge SYS_CLK_IN);
		#1 check("early", pulses[7:0], 8'h00);
		check("corr", {7'h00, CORR_SECOND_OUT}, 8'h00);
		repeat (2) @(posedge SYS_CLK_IN) OSC_IN <= ~OSC_IN;
		repeat (9) @(posedge SYS_CLK_IN);
		#1 check("pulses", pulses[7:0], 8'h01);
		check("raw", {7'h00, RAW_OSC_OUT}, 8'h01);
		$display("test second done");
		end_of_test();
	end
endmodule

/* dv/trim_host_model.sv */
// Purpose: Host that writes the trim register
// Assumes: Called between clock edges
// Notes:   Data shows the inverse once released
`timescale 1ns/10ps
module trim_host_model (
	input  wire logic       clk_in,
	output logic            wr_out,
	output logic      [7:0] wd_out
);
	initial {wr_out, wd_out} = 9'h000;
	task automatic put(input logic [7:0] d);
		@(posedge clk_in) wr_out <= 1'b1;
		wd_out <= d;
		@(posedge clk_in) wr_out <= 1'b0;
		wd_out <= ~d;
	endtask
endmodule

/* pkg/rtc_rate_trim_pkg.sv */
// Purpose: Shared constants for the rate-trim unit of the real-time clock.
// Assumes: Crystal tick arrives as a square wave at 32768 Hz.
// Notes:   Trim control register layout and correction-period constants.
package rtc_rate_trim_pkg;
	localparam int unsigned      TICK_CNT_W        = 16;
	localparam int unsigned      ADJ_W             = 9;
	localparam int unsigned      SEC_CNT_W         = 6;
	localparam int unsigned      TRIM_W            = 7;
	localparam int unsigned      REG_W             = 8;
	localparam logic [15:0]      TICKS_PER_SEC     = 16'h8000;
	localparam logic [5:0]       PERIOD_SHORT_SEC  = 6'h14;
	localparam logic [5:0]       PERIOD_LONG_SEC   = 6'h3c;
	localparam int unsigned      PERIOD_SEL_BIT    = 7;
	localparam int unsigned      TRIM_SIGN_BIT     = 6;
	localparam logic [7:0]       TRIM_REG_RESET    = 8'h00;
	localparam logic [6:0]       TRIM_NEG_NULL_LO  = 7'h40;
	localparam logic [6:0]       TRIM_NEG_NULL_HI  = 7'h41;
	localparam logic [6:0]       TRIM_POS_OFFSET   = 7'h01;
	localparam logic [7:0]       TRIM_NEG_BASE     = 8'h80;
	localparam int unsigned      TRIM_STEP_SHIFT   = 1;
endpackage

/* rtl/rtc_rate_trim.sv */
// Purpose: Digital rate trim; stretches or shrinks one second per correction period.
// Assumes: OSC_IN is the crystal square wave, asynchronous to SYS_CLK_IN.
// Notes:   Trim register written through a plain strobe from the serial port logic.
//
// Contract
// - Correct rate by counting pulses, not oscillator
// - Period select 0: correct every 20 s
// - Period select 1: correct every 60 s
// - Upper six trim bits zero disable correction
// - Seven-bit signed trim field, bits 0-6
// - Codes 0, +1, -64, -63 are neutral
// - Select 0: about 3.051 ppm per count
// - Select 1: about 1.017 ppm per count
// - Negative trim coded as 128 minus magnitude
// - Raw oscillator output is never trimmed
`timescale 1ns/10ps
module rtc_rate_trim (
	input  wire logic       SYS_CLK_IN,
	input  wire logic       RST_IN,
	input  wire logic       OSC_IN,
	input  wire logic       TRIM_WR_IN,
	input  wire logic [7:0] TRIM_WDATA_IN,
	output logic      [7:0] TRIM_RDATA_OUT,
	output logic            SEC_PULSE_OUT,
	output logic            CORR_SECOND_OUT,
	output logic            RAW_OSC_OUT
);
	logic        osc_meta_q;
	logic        osc_sync_q;
	logic        osc_prev_q;
	logic        tick;

	logic [7:0]  trim_reg_q;
	logic [7:0]  trim_reg_d;
	logic [7:0]  trim_act_q;
	logic [7:0]  trim_act_d;

	logic [15:0] tick_cnt_q;
	logic [15:0] tick_cnt_d;
	logic [5:0]  sec_cnt_q;
	logic [5:0]  sec_cnt_d;
	logic        sec_pulse_q;
	logic        raw_osc_q;

	logic [8:0]  adj_ticks;
	logic [5:0]  period_len;
	logic        corr_second;
	logic [15:0] sec_len;
	logic        sec_end;
	logic        period_end;
	logic [15:0] adj_ext;
	logic [15:0] corr_len;
	logic [15:0] last_tick;
	logic [5:0]  last_sec;
	logic [15:0] tick_next;
	logic [5:0]  sec_next;
	logic        raw_osc_d;
	logic        sec_pulse_d;

	// Only the second stage of the synchroniser is looked at
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			osc_meta_q <= 1'b0;
		end else begin
			osc_meta_q <= OSC_IN;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			osc_sync_q <= 1'b0;
		end else begin
			osc_sync_q <= osc_meta_q;
		end
	end

	// Edge detector history resets to the idle low level, so a crystal already high at reset release still gives one tick
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			osc_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_sync_q;
		end
	end

	assign tick = osc_sync_q & ~osc_prev_q;

	// Untrimmed clock out
	// Taken before any trim logic, so the correction can never reach this pin
	assign raw_osc_d = osc_sync_q;

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			raw_osc_q <= 1'b0;
		end else begin
			raw_osc_q <= raw_osc_d;
		end
	end

	// Host keeps codes in range; out-of-range patterns are stored as written
	assign trim_reg_d = TRIM_WR_IN ? TRIM_WDATA_IN : trim_reg_q;

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			trim_reg_q <= rtc_rate_trim_pkg::TRIM_REG_RESET;
		end else begin
			trim_reg_q <= trim_reg_d;
		end
	end

	assign trim_act_d = period_end ? trim_reg_q : trim_act_q;

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			trim_act_q <= rtc_rate_trim_pkg::TRIM_REG_RESET;
		end else begin
			trim_act_q <= trim_act_d;
		end
	end

	// Decoding only the active copy keeps a mid-period write from bending the second in flight
	rtc_trim_decode u_decode (
		.trim_code_in  (trim_act_q[6:0]),
		.adj_ticks_out (adj_ticks)
	);

	assign period_len = trim_act_q[rtc_rate_trim_pkg::PERIOD_SEL_BIT] ?
	                    rtc_rate_trim_pkg::PERIOD_LONG_SEC : rtc_rate_trim_pkg::PERIOD_SHORT_SEC;

	// The last second of each period carries the whole correction
	assign last_sec    = period_len - 6'h01;
	assign corr_second = (sec_cnt_q == last_sec);

	// Sign-extend once so the sum stays 16 bits; a negative code shortens the second
	assign adj_ext  = {{7{adj_ticks[8]}}, adj_ticks};
	assign corr_len = rtc_rate_trim_pkg::TICKS_PER_SEC + adj_ext;

	assign sec_len   = corr_second ? corr_len : rtc_rate_trim_pkg::TICKS_PER_SEC;
	assign last_tick = sec_len - 16'h0001;

	// A second ends only on a tick, so a stopped crystal freezes the count
	assign sec_end    = tick && (tick_cnt_q == last_tick);
	assign period_end = sec_end && corr_second;

	assign tick_next   = tick_cnt_q + 16'h0001;
	assign sec_next    = sec_cnt_q + 6'h01;
	assign tick_cnt_d  = sec_end ? 16'h0000 : (tick ? tick_next : tick_cnt_q);
	assign sec_cnt_d   = period_end ? 6'h00 : (sec_end ? sec_next : sec_cnt_q);
	assign sec_pulse_d = sec_end;

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// Restarting at zero on reset aligns the first period with the release of reset
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			sec_cnt_q <= 6'h00;
		end else begin
			sec_cnt_q <= sec_cnt_d;
		end
	end

	// Registered so the pulse is one clock wide and free of decode glitches
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			sec_pulse_q <= 1'b0;
		end else begin
			sec_pulse_q <= sec_pulse_d;
		end
	end

	assign TRIM_RDATA_OUT  = trim_reg_q;
	assign SEC_PULSE_OUT   = sec_pulse_q;
	assign CORR_SECOND_OUT = corr_second;
	assign RAW_OSC_OUT     = raw_osc_q;
endmodule

/* rtl/rtc_trim_decode.sv */
// Purpose: Turns the 7-bit signed trim code into a signed tick adjustment.
// Assumes: Pure combinational; code comes from the active trim latch.
// Notes:   Positive result lengthens the corrected second, negative shortens it.
`timescale 1ns/10ps
module rtc_trim_decode (
	input  wire logic [6:0] trim_code_in,
	output logic      [8:0] adj_ticks_out
);
	logic        upper_zero;
	logic        neg_null;
	logic        is_neg;
	logic [6:0]  pos_steps;
	logic [7:0]  neg_steps;
	logic [8:0]  pos_adj;
	logic [8:0]  neg_adj;

	assign upper_zero = (trim_code_in[6:1] == 6'h00);
	assign neg_null   = (trim_code_in == rtc_rate_trim_pkg::TRIM_NEG_NULL_LO) ||
	                    (trim_code_in == rtc_rate_trim_pkg::TRIM_NEG_NULL_HI);
	assign is_neg     = trim_code_in[rtc_rate_trim_pkg::TRIM_SIGN_BIT];
	assign pos_steps  = trim_code_in - rtc_rate_trim_pkg::TRIM_POS_OFFSET;
	assign neg_steps  = rtc_rate_trim_pkg::TRIM_NEG_BASE - {1'b0, trim_code_in};
	// Each step is two crystal ticks, giving the stated ppm per count
	assign pos_adj    = {1'b0, pos_steps, 1'b0};
	assign neg_adj    = 9'h000 - {neg_steps, 1'b0};
	assign adj_ticks_out = (upper_zero || neg_null) ? 9'h000 :
	                       (is_neg ? neg_adj : pos_adj);
endmodule
